// ### rtl/acr_map.svh
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets (low address byte)
// ---------------------------------------------------------------
`define ACR_OFS_CTL0 8'h00
`define ACR_OFS_CTL1 8'h04
`define ACR_OFS_TRG 8'h08
`define ACR_OFS_RESH 8'h0C
`define ACR_OFS_RESL 8'h10
`define ACR_OFS_ISTS 8'h14
`define ACR_OFS_IEN 8'h18
`define ACR_OFS_ICLR 8'h1C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACR_CTL0_EN_BIT 0
`define ACR_CTL0_GO_BIT 1
`define ACR_CTL0_CHS_LSB 2
`define ACR_CTL1_FMT_BIT 7
`define ACR_CTL1_CKS_LSB 4
`define ACR_CTL1_PREF_LSB 0
`define ACR_IRQ_DONE_BIT 0
`define ACR_IRQ_TRIG_BIT 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ACR_RST_CTL0 8'h00
`define ACR_RST_CTL1 8'h00
`define ACR_RST_TRG 4'h0
`define ACR_RST_IRQ 2'h0

// ---------------------------------------------------------------
// channel codes
// ---------------------------------------------------------------
`define ACR_CHS_AGND 6'h3B
`define ACR_CHS_PA_LAST 6'h05
`define ACR_CHS_PB_FIRST 6'h0C
`define ACR_CHS_PB_LAST 6'h0F
`define ACR_CHS_PC_FIRST 6'h10
`define ACR_CHS_PC_LAST 6'h17
`define ACR_CHS_PC_SMALL_LAST 6'h15

// ---------------------------------------------------------------
// conversion clock dividers
// ---------------------------------------------------------------
`define ACR_DIV_000 7'h02
`define ACR_DIV_001 7'h08
`define ACR_DIV_010 7'h20
`define ACR_DIV_100 7'h04
`define ACR_DIV_101 7'h10
`define ACR_DIV_110 7'h40
`define ACR_CKS_RC_LOW 2'h3

// ---------------------------------------------------------------
// reference codes
// ---------------------------------------------------------------
`define ACR_PREF_VDD 2'h0
`define ACR_PREF_EXT 2'h2
`define ACR_PREF_FVR 2'h3

`endif

// ### rtl/acr_pkg.sv
package acr_pkg;

`include "acr_map.svh"

  typedef enum logic [0:0] {
    ACR_IDLE = 1'b0,
    ACR_CONV = 1'b1
  } acr_state_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } acr_res_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } acr_div_t;

  typedef struct packed {
    acr_state_t state;
    logic [5:0] channel_select;
    logic en;
    logic fmt;
    logic [2:0] cks;
    logic [1:0] pref;
    logic [3:0] trg;
    logic [15:0] trig_prev;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic hready;
    logic [31:0] hrdata;
    logic start_p;
    logic tick;
    logic irq;
    logic [5:0] pa_sel;
    logic [3:0] pb_sel;
    logic [7:0] pc_sel;
    logic [4:0] isrc_sel;
    logic [2:0] ref_sel;
  } acr_st_t;

  function automatic logic [6:0] acr_div_of(input logic [2:0] code);
    case (code)
      3'h0: acr_div_of = `ACR_DIV_000;
      3'h1: acr_div_of = `ACR_DIV_001;
      3'h2: acr_div_of = `ACR_DIV_010;
      3'h4: acr_div_of = `ACR_DIV_100;
      3'h5: acr_div_of = `ACR_DIV_101;
      3'h6: acr_div_of = `ACR_DIV_110;
      default: acr_div_of = `ACR_DIV_000;
    endcase
  endfunction : acr_div_of

  function automatic acr_res_t acr_pack_res(input logic fmt, input logic [9:0] r);
    acr_res_t v;
    if (fmt) begin
      v.hi = {6'h00, r[9:8]};
      v.lo = r[7:0];
    end else begin
      v.hi = r[9:2];
      v.lo = {r[1:0], 6'h00};
    end
    return v;
  endfunction : acr_pack_res

endpackage : acr_pkg

// ### rtl/acr_clkdiv.sv
`timescale 1ns/1ps
module acr_clkdiv
  import acr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [2:0] sel,
  input wire logic run,
  input wire logic rc_tick,
  // tick out
  output logic tick
);

  acr_div_t st_ff;
  acr_div_t nxt_st;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 7'h00;
    end else if (sel[1:0] == `ACR_CKS_RC_LOW) begin
      nxt_st.cnt = 7'h00;
      nxt_st.tick = rc_tick;
    end else if (st_ff.cnt >= acr_div_of(sel) - 7'h01) begin
      nxt_st.cnt = 7'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : acr_clkdiv

// ### rtl/acr_top.sv
`timescale 1ns/1ps
module acr_top
  import acr_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // analog core
  input wire logic CONV_DONE,
  input wire logic [9:0] CONV_DATA,
  input wire logic RC_TICK,
  output logic CONV_ENABLE,
  output logic CONV_START,
  output logic CONV_BUSY,
  output logic CONV_CLK_TICK,
  // trigger sources, bit 0 unused
  input wire logic [15:0] TRIG_SRC,
  // input and reference routing
  output logic [5:0] PORTA_SEL,
  output logic [3:0] PORTB_SEL,
  output logic [7:0] PORTC_SEL,
  output logic [4:0] INT_SRC_SEL,
  output logic [2:0] REF_SEL,
  // interrupt
  output logic IRQ
);

  acr_st_t st_ff;
  acr_st_t nxt_st;
  acr_res_t res_ff;
  acr_res_t nxt_res;
  logic div_tick;

  // ---------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------
  acr_clkdiv u_clkdiv (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .sel(st_ff.cks),
    .run(st_ff.en),
    .rc_tick(RC_TICK),
    .tick(div_tick)
  );

  // ---------------------------------------------------------------
  // one-hot decode
  // ---------------------------------------------------------------
  function automatic logic [15:0] onehot_of(input logic [3:0] idx);
    onehot_of = 16'h0001 << idx;
  endfunction : onehot_of

  // ---------------------------------------------------------------
  // register read-back
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input acr_st_t s, input acr_res_t r);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (s.dp_addr)
      `ACR_OFS_CTL0: begin
        w[7:2] = s.channel_select;
        w[`ACR_CTL0_GO_BIT] = (s.state == ACR_CONV);
        w[`ACR_CTL0_EN_BIT] = s.en;
      end
      `ACR_OFS_CTL1: begin
        w[`ACR_CTL1_FMT_BIT] = s.fmt;
        w[6:4] = s.cks;
        w[1:0] = s.pref;
      end
      `ACR_OFS_TRG: begin
        w[3:0] = s.trg;
      end
      `ACR_OFS_RESH: begin
        w[7:0] = r.hi;
      end
      `ACR_OFS_RESL: begin
        w[7:0] = r.lo;
      end
      `ACR_OFS_ISTS: begin
        w[1:0] = s.irq_sts;
      end
      `ACR_OFS_IEN: begin
        w[1:0] = s.irq_en;
      end
      `ACR_OFS_ICLR: begin
        w = 32'h0000_0000; // write-only, reads zero
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] trg_oh;
    logic trig_edge;
    logic sw_start;
    logic sw_abort;
    logic wr_now;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [31:0] rd;
    trg_oh = 16'h0000;
    trig_edge = 1'b0;
    sw_start = 1'b0;
    sw_abort = 1'b0;
    wr_now = 1'b0;
    ev = 2'h0;
    clr = 2'h0;
    rd = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_res = res_ff;
    nxt_st.start_p = 1'b0;

    // -------------------------------------------------------------
    // trigger edge detect
    // -------------------------------------------------------------
    trg_oh = onehot_of(st_ff.trg);
    if (st_ff.trg != 4'h0) begin
      trig_edge = |(TRIG_SRC & ~st_ff.trig_prev & trg_oh);
    end
    nxt_st.trig_prev = TRIG_SRC;

    // -------------------------------------------------------------
    // bus data phase
    // -------------------------------------------------------------
    wr_now = st_ff.dp_valid & st_ff.dp_write & st_ff.hready;
    if (st_ff.dp_valid & st_ff.hready) begin
      nxt_st.dp_valid = 1'b0;
    end
    if (st_ff.dp_valid & ~st_ff.dp_write & ~st_ff.hready) begin
      rd = read_word(st_ff, res_ff);
      nxt_st.hrdata = rd;
      nxt_st.hready = 1'b1;
    end

    // -------------------------------------------------------------
    // bus address phase
    // -------------------------------------------------------------
    if (HSEL & HTRANS[1] & HREADY) begin
      nxt_st.dp_valid = 1'b1;
      nxt_st.dp_write = HWRITE;
      nxt_st.dp_addr = {HADDR[7:2], 2'h0};
      nxt_st.hready = HWRITE;
    end

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    if (wr_now) begin
      case (st_ff.dp_addr)
        `ACR_OFS_CTL0: begin
          nxt_st.channel_select = HWDATA[7:2];
          nxt_st.en = HWDATA[`ACR_CTL0_EN_BIT];
          sw_start = HWDATA[`ACR_CTL0_GO_BIT];
          sw_abort = ~HWDATA[`ACR_CTL0_GO_BIT];
        end
        `ACR_OFS_CTL1: begin
          nxt_st.fmt = HWDATA[`ACR_CTL1_FMT_BIT];
          nxt_st.cks = HWDATA[6:4];
          nxt_st.pref = HWDATA[1:0];
        end
        `ACR_OFS_TRG: begin
          nxt_st.trg = HWDATA[3:0];
        end
        `ACR_OFS_RESH: begin
          nxt_res.hi = HWDATA[7:0];
        end
        `ACR_OFS_RESL: begin
          nxt_res.lo = HWDATA[7:0];
        end
        `ACR_OFS_IEN: begin
          nxt_st.irq_en = HWDATA[1:0];
        end
        `ACR_OFS_ICLR: begin
          clr = HWDATA[1:0];
        end
        default: begin
          clr = 2'h0;
        end
      endcase
    end

    // -------------------------------------------------------------
    // conversion sequencer
    // -------------------------------------------------------------
    case (st_ff.state)
      ACR_IDLE: begin
        if (nxt_st.en & (sw_start | trig_edge)) begin
          nxt_st.state = ACR_CONV;
          nxt_st.start_p = 1'b1;
          ev[`ACR_IRQ_TRIG_BIT] = trig_edge & ~sw_start;
        end
      end
      ACR_CONV: begin
        if (~nxt_st.en | sw_abort) begin
          nxt_st.state = ACR_IDLE;
        end else if (CONV_DONE) begin
          nxt_res = acr_pack_res(nxt_st.fmt, CONV_DATA);
          nxt_st.state = ACR_IDLE;
          ev[`ACR_IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        nxt_st.state = ACR_IDLE;
      end
    endcase

    // -------------------------------------------------------------
    // interrupt, set wins over clear
    // -------------------------------------------------------------
    nxt_st.irq_sts = (st_ff.irq_sts & ~clr) | ev;
    nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_en);

    // -------------------------------------------------------------
    // conversion clock tick
    // -------------------------------------------------------------
    nxt_st.tick = div_tick & st_ff.en;

    // -------------------------------------------------------------
    // channel routing
    // -------------------------------------------------------------
    nxt_st.pa_sel = 6'h00;
    nxt_st.pb_sel = 4'h0;
    nxt_st.pc_sel = 8'h00;
    nxt_st.isrc_sel = 5'h00;
    if (nxt_st.channel_select >= `ACR_CHS_AGND) begin
      nxt_st.isrc_sel = 5'(onehot_of(4'(nxt_st.channel_select - `ACR_CHS_AGND)));
    end else if (nxt_st.channel_select <= `ACR_CHS_PA_LAST) begin
      nxt_st.pa_sel = 6'(onehot_of({1'b0, nxt_st.channel_select[2:0]}));
    end else if (nxt_st.channel_select >= `ACR_CHS_PB_FIRST && nxt_st.channel_select <= `ACR_CHS_PB_LAST) begin
      if (LARGE_VARIANT) begin
        nxt_st.pb_sel = 4'(onehot_of({2'h0, nxt_st.channel_select[1:0]}));
      end
    end else if (nxt_st.channel_select >= `ACR_CHS_PC_FIRST && nxt_st.channel_select <= `ACR_CHS_PC_LAST) begin
      if (LARGE_VARIANT || nxt_st.channel_select <= `ACR_CHS_PC_SMALL_LAST) begin
        nxt_st.pc_sel = 8'(onehot_of({1'b0, nxt_st.channel_select[2:0]}));
      end
    end

    // -------------------------------------------------------------
    // reference routing, reserved code connects nothing
    // -------------------------------------------------------------
    case (nxt_st.pref)
      `ACR_PREF_VDD: nxt_st.ref_sel = 3'h1;
      `ACR_PREF_EXT: nxt_st.ref_sel = 3'h2;
      `ACR_PREF_FVR: nxt_st.ref_sel = 3'h4;
      default: nxt_st.ref_sel = 3'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= '0;
      st_ff.hready <= 1'b1;
      st_ff.ref_sel <= 3'h1;
      st_ff.pa_sel <= 6'h01;
      st_ff.trg <= `ACR_RST_TRG;
      st_ff.irq_sts <= `ACR_RST_IRQ;
      st_ff.irq_en <= `ACR_RST_IRQ;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // result registers, held across reset
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    res_ff <= nxt_res;
  end

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  assign HREADYOUT = st_ff.hready;
  assign HRESP = 1'b0;
  assign HRDATA = st_ff.hrdata;

  // ---------------------------------------------------------------
  // converter outputs
  // ---------------------------------------------------------------
  assign CONV_ENABLE = st_ff.en;
  assign CONV_START = st_ff.start_p;
  assign CONV_BUSY = (st_ff.state == ACR_CONV);
  assign CONV_CLK_TICK = st_ff.tick;

  // ---------------------------------------------------------------
  // routing outputs
  // ---------------------------------------------------------------
  assign PORTA_SEL = st_ff.pa_sel;
  assign PORTB_SEL = st_ff.pb_sel;
  assign PORTC_SEL = st_ff.pc_sel;
  assign INT_SRC_SEL = st_ff.isrc_sel;
  assign REF_SEL = st_ff.ref_sel;

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  assign IRQ = st_ff.irq;

endmodule : acr_top

// ### verification/acr_top_assertions.sv
`timescale 1ns/1ps
module acr_top_assertions
  import acr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  // converter
  input wire logic CONV_DONE,
  input wire logic CONV_ENABLE,
  input wire logic CONV_START,
  input wire logic CONV_BUSY,
  input wire logic CONV_CLK_TICK
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  wire logic rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;
  // ------
  // checks
  // ------
  chk_busy_needs_en: assert property (CONV_BUSY |-> CONV_ENABLE)
    else $error("busy while disabled");
  chk_start_sets_busy: assert property (CONV_START |-> CONV_BUSY)
    else $error("start without busy");
  chk_start_one_cycle: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse too long");
  chk_busy_rise_start: assert property ($rose(CONV_BUSY) |-> CONV_START)
    else $error("busy rose without start");
  chk_done_clears_busy: assert property (CONV_BUSY && CONV_DONE |=> !CONV_BUSY)
    else $error("busy kept after done");
  chk_tick_when_off: assert property (!CONV_ENABLE [*2] |-> !CONV_CLK_TICK)
    else $error("clock tick while disabled");
  chk_read_wait_one: assert property (rd_req |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait not one cycle");
  chk_rdata_upper_zero: assert property (HREADYOUT |-> HRDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  cover property (CONV_START);
  cover property (CONV_BUSY && CONV_DONE);
  cover property (rd_req);
endmodule : acr_top_assertions

bind acr_top acr_top_assertions u_chk (.*);

// ### verification/acr_tb_top.sv
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_tb_top
  import acr_pkg::*;
;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int rcn = 0;
  logic SYS_CLK = 1'h0, SYS_RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0;
  logic CONV_DONE = 1'h0, RC_TICK = 1'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [9:0] CONV_DATA = 10'h000;
  logic [15:0] TRIG_SRC = 16'h0000;
  logic HREADYOUT, HRESP, CONV_ENABLE, CONV_START, CONV_BUSY, CONV_CLK_TICK, IRQ;
  logic [5:0] PORTA_SEL;
  logic [3:0] PORTB_SEL;
  logic [7:0] PORTC_SEL;
  logic [4:0] INT_SRC_SEL;
  logic [2:0] REF_SEL;
  wire logic HREADY = HREADYOUT;
  acr_top dut (.*);
  // -------------
  // clock, rc, hang limit
  // -------------
  initial begin
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    rcn <= (rcn == 4) ? 0 : rcn + 1;
    RC_TICK <= (rcn == 4);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  // -------------
  // helpers
  // -------------
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rdy(output logic [31:0] q);
    @(negedge SYS_CLK);
    while (HREADYOUT !== 1'h1) @(negedge SYS_CLK);
    q = HRDATA;
    @(posedge SYS_CLK);
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h000000, a};
    rdy(q);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy(q);
    chk("hresp", HRESP, 1'h0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, {24'h000000, d}, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rdc
  task automatic irq_is(input logic e);
    repeat (2) @(negedge SYS_CLK);
    chk("irq", IRQ, e);
    @(posedge SYS_CLK);
  endtask : irq_is
  task automatic done_p(input logic [9:0] r);
    CONV_DONE <= 1'h1;
    CONV_DATA <= r;
    @(posedge SYS_CLK);
    CONV_DONE <= 1'h0;
    CONV_DATA <= ~r;
    @(negedge SYS_CLK);
    chk("busy_clr", CONV_BUSY, 1'h0);
    @(posedge SYS_CLK);
  endtask : done_p
  task automatic tk(output int n);
    n = 0;
    do begin
      @(negedge SYS_CLK);
      n++;
    end while (CONV_CLK_TICK !== 1'h1);
  endtask : tk
  // -------------
  // scenarios
  // -------------
  task automatic t_rst(input logic keep);
    SYS_RST <= 1'h1;
    repeat (16) @(posedge SYS_CLK);
    SYS_RST <= 1'h0;
    @(posedge SYS_CLK);
    rdc(`ACR_OFS_CTL0, 32'h0, "ctl0");
    rdc(`ACR_OFS_CTL1, 32'h0, "ctl1");
    rdc(`ACR_OFS_TRG, 32'h0, "trg");
    rdc(`ACR_OFS_IEN, 32'h0, "ien");
    chk("sel_rst", {PORTA_SEL, REF_SEL}, 9'h009);
    if (keep) begin
      rdc(`ACR_OFS_RESH, 32'h01, "resh_kept");
      rdc(`ACR_OFS_RESL, 32'hC3, "resl_kept");
    end
  endtask : t_rst
  task automatic t_regs;
    wr(`ACR_OFS_CTL1, 8'hFF);
    rdc(`ACR_OFS_CTL1, 32'hF3, "ctl1_rw");
    wr(`ACR_OFS_TRG, 8'hFF);
    rdc(`ACR_OFS_TRG, 32'h0F, "trg_rw");
    rdc(8'h20, 32'h0, "unmapped");
    rdc(`ACR_OFS_ICLR, 32'h0, "clr_reads");
  endtask : t_regs
  task automatic t_sel;
    logic [63:0] oh;
    logic [22:0] e;
    for (int c = 0; c < 64; c++) begin
      oh = 64'h1 << c;
      e = {oh[5:0], oh[15:12], oh[23:16], oh[63:59]};
      wr(`ACR_OFS_CTL0, 8'(c << 2));
      repeat (2) @(negedge SYS_CLK);
      chk("chan", {PORTA_SEL, PORTB_SEL, PORTC_SEL, INT_SRC_SEL}, e);
      @(posedge SYS_CLK);
    end
    for (int p = 0; p < 4; p++) begin
      oh = 64'h1 << p;
      wr(`ACR_OFS_CTL1, 8'(p));
      repeat (2) @(negedge SYS_CLK);
      chk("ref", REF_SEL, {oh[3:2], oh[0]});
      @(posedge SYS_CLK);
    end
  endtask : t_sel
  task automatic t_clk;
    int p[8] = '{2, 8, 32, 5, 4, 16, 64, 5};
    int n;
    wr(`ACR_OFS_CTL0, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(`ACR_OFS_CTL1, 8'(c << 4));
      repeat (3) tk(n);
      chk("clk_div", n, p[c]);
      @(posedge SYS_CLK);
    end
  endtask : t_clk
  task automatic t_conv(input logic fmt);
    logic [9:0] r;
    r = 10'h2A5;
    wr(`ACR_OFS_IEN, 8'h01);
    wr(`ACR_OFS_CTL1, {fmt, 7'h00});
    wr(`ACR_OFS_CTL0, 8'h03);
    @(negedge SYS_CLK);
    chk("en_start", {CONV_ENABLE, CONV_START}, 2'h3);
    @(posedge SYS_CLK);
    rdc(`ACR_OFS_CTL0, 32'h03, "go_busy");
    done_p(r);
    irq_is(1'h1);
    rdc(`ACR_OFS_CTL0, 32'h01, "go_clr");
    rdc(`ACR_OFS_RESH, fmt ? {30'h0, r[9:8]} : {24'h0, r[9:2]}, "hi");
    rdc(`ACR_OFS_RESL, fmt ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00}, "lo");
    rdc(`ACR_OFS_ISTS, 32'h01, "sts");
    wr(`ACR_OFS_ICLR, 8'h01);
    irq_is(1'h0);
  endtask : t_conv
  task automatic t_abort;
    wr(`ACR_OFS_CTL0, 8'h03);
    wr(`ACR_OFS_CTL0, 8'h01);
    rdc(`ACR_OFS_CTL0, 32'h01, "abort_idle");
    done_p(10'h000);
    rdc(`ACR_OFS_RESL, 32'hA5, "abort_keep");
    rdc(`ACR_OFS_ISTS, 32'h00, "abort_sts");
  endtask : t_abort
  task automatic t_trig;
    wr(`ACR_OFS_IEN, 8'h00);
    wr(`ACR_OFS_TRG, 8'h04);
    TRIG_SRC <= 16'h0010;
    repeat (2) @(posedge SYS_CLK);
    rdc(`ACR_OFS_CTL0, 32'h03, "trig_go");
    done_p(10'h1C3);
    irq_is(1'h0);
    wr(`ACR_OFS_IEN, 8'h03);
    irq_is(1'h1);
    TRIG_SRC <= 16'h0000;
    wr(`ACR_OFS_ICLR, 8'h03);
    irq_is(1'h0);
    rdc(`ACR_OFS_CTL0, 32'h01, "fall_idle");
    wr(`ACR_OFS_TRG, 8'h00);
    TRIG_SRC <= 16'hFFFE;
    repeat (3) @(posedge SYS_CLK);
    rdc(`ACR_OFS_CTL0, 32'h01, "trg_off");
    wr(`ACR_OFS_CTL0, 8'h00);
    wr(`ACR_OFS_TRG, 8'h04);
    TRIG_SRC <= 16'h0000;
    @(posedge SYS_CLK);
    TRIG_SRC <= 16'h0010;
    repeat (3) @(posedge SYS_CLK);
    wr(`ACR_OFS_CTL0, 8'h02);
    rdc(`ACR_OFS_CTL0, 32'h00, "off_start");
  endtask : t_trig
  initial begin
    t_rst(1'h0);
    t_regs();
    t_sel();
    t_clk();
    t_conv(1'h0);
    t_conv(1'h1);
    t_abort();
    t_trig();
    t_rst(1'h1);
    tally_and_finish();
  end
endmodule : acr_tb_top
